// *** rtl/fpc_pkg.sv ***
// shared constants and types for the defect pixel correction block
package fpc_pkg;

  // register map, byte offsets on the register port
  localparam int          REG_AW       = 5;
  localparam logic [4:0]  OFS_CTRL     = 5'h00;
  localparam logic [4:0]  OFS_TSA      = 5'h04;
  localparam logic [4:0]  OFS_IRQ_STAT = 5'h08;
  localparam logic [4:0]  OFS_IRQ_MASK = 5'h0c;
  localparam logic [4:0]  OFS_POS      = 5'h10;

  // control register fields
  localparam int          EN_BIT       = 15;
  localparam int          ERR_BIT      = 16;
  localparam int          CNT_W        = 15;
  localparam logic [14:0] CNT_RESET    = 15'h0000;
  localparam logic [31:0] TSA_RESET    = 32'h0000_0000;

  // table fetch geometry
  localparam int          ALIGN_LSB    = 6;
  localparam int          ENTRY_SHIFT  = 2;

  // interrupt status bits
  localparam int          IRQ_W        = 2;
  localparam int          IRQ_LATE     = 0;
  localparam int          IRQ_WRAP     = 1;
  localparam logic [1:0]  IRQ_RESET    = 2'h0;

  // entry layout and operation codes
  localparam int          LINE_W       = 13;
  localparam int          HPOS_W       = 14;
  localparam int          OP_W         = 5;
  localparam logic [4:0]  OP_RSVD      = 5'h12;  // first code with no operation
  localparam int          REACH        = 6;
  localparam int          WIN_N        = 2 * REACH + 1;
  localparam int          CEN          = REACH;

  // one table entry as it sits in memory
  typedef struct packed {
    logic [LINE_W-1:0] line;
    logic [HPOS_W-1:0] hpos;
    logic [OP_W-1:0]   op;
  } entry_t;

  // one register port request
  typedef struct packed {
    logic [REG_AW-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

endpackage

// *** rtl/neighbour_select.sv ***
// picks or averages neighbour pixels for one operation code
`timescale 1ns/10ps
module neighbour_select
#(
  parameter int PIX_W = 10
)
(
  // pixel window, index 0 is the newest pixel
  input  wire logic [fpc_pkg::WIN_N-1:0][PIX_W-1:0] win,
  // operation code of the entry
  input  wire logic [fpc_pkg::OP_W-1:0]             op,
  // replacement value and code validity
  output logic      [PIX_W-1:0]                     pix,
  output logic                                      op_ok
);
  import fpc_pkg::*;

  // distance n of the operation, 1 to 6
  function automatic logic [2:0] op_reach(input logic [OP_W-1:0] code);
    op_reach = 3'(code / 5'h03) + 3'h1;
  endfunction

  // 0 average, 1 left, 2 right
  function automatic logic [1:0] op_kind(input logic [OP_W-1:0] code);
    op_kind = 2'(code % 5'h03);
  endfunction

  logic [2:0]       n;
  logic [PIX_W-1:0] left;
  logic [PIX_W-1:0] right;
  logic [PIX_W:0]   sum;

  // older pixels sit at higher indices, so x-n is cen+n
  always_comb
  begin
    op_ok = op < OP_RSVD;                           // RL13
    // reserved codes would reach past the window, so pin them to n=1
    n     = op_ok ? op_reach(op) : 3'h1;
    left  = win[CEN + int'(n)];
    right = win[CEN - int'(n)];
    sum   = {1'b0, left} + {1'b0, right};
    case (op_kind(op))
      2'h0:    pix = sum[PIX_W:1];                  // RL9
      2'h1:    pix = left;                          // RL10
      2'h2:    pix = right;                         // RL11
      default: pix = win[CEN];
    endcase
  end

endmodule

// *** rtl/defect_pixel_correct.sv ***
// defect pixel correction: table fetch, raster match, pixel replacement
//
// Contract
// RL1: keep fetching while enabled, wrap after last
// RL2: enable write starts fetching at once
// RL3: software writes address, disable, then enable
// RL4: defect count latched at vertical sync
// RL5: bit 15 enables correction, 0 off
// RL6: six low address bits ignored
// RL7: entry holds line, pixel and opcode
// RL8: opcode in bits 4:0 selects replacement
// RL9: average codes use x-n and x+n
// RL10: left codes copy pixel x-n
// RL11: right codes copy pixel x+n
// RL12: late entry flags error, stops frame
// RL13: codes 18 to 31 do nothing
// RL14: apply entry when line and pixel match
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
module defect_pixel_correct
#(
  parameter int PIX_W = 10
)
(
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 reset_n,
  // register port
  input  wire fpc_pkg::reg_req_t    reg_req,
  output logic [31:0]               reg_rdata,
  // table fetch to memory
  output logic                      mem_req,
  output logic [31:0]               mem_addr,
  input  wire logic                 mem_rvalid,
  input  wire logic [31:0]          mem_rdata,
  // pixel stream in
  input  wire logic                 vertical_sync,
  input  wire logic                 line_start,
  input  wire logic                 pix_valid,
  input  wire logic [PIX_W-1:0]     pix_data,
  // pixel stream out
  output logic                      out_valid,
  output logic [PIX_W-1:0]          out_data,
  // interrupt
  output logic                      irq
);
  import fpc_pkg::*;

  typedef enum logic [0:0] {
    F_IDLE = 1'b0,
    F_WAIT = 1'b1
  } fetch_state_t;

  fetch_state_t               fstate_reg;
  logic                       en_reg;
  logic [CNT_W-1:0]           dcount_reg;
  logic [CNT_W-1:0]           cnt_reg;
  logic [31:0]                tsa_reg;
  logic [IRQ_W-1:0]           stat_reg;
  logic [IRQ_W-1:0]           mask_reg;
  logic                       frame_err_reg;
  logic [CNT_W-1:0]           idx_reg;
  logic                       wrap_reg;
  logic                       restart_reg;
  logic                       ent_valid_reg;
  logic                       ent_next_reg;
  entry_t                     ent_reg;
  logic [LINE_W-1:0]          line_reg;
  logic [HPOS_W-1:0]          x_reg;
  logic [WIN_N-1:0][PIX_W-1:0] win_reg;
  logic                       mem_req_reg;
  logic [31:0]                mem_addr_reg;
  logic [31:0]                rdata_reg;
  logic                       out_valid_reg;
  logic [PIX_W-1:0]           out_data_reg;
  logic                       irq_reg;

  logic                       ctl_wr;
  logic                       en_rise;
  logic [WIN_N-1:0][PIX_W-1:0] win_next;
  logic [31:0]                base;
  logic                       cen_ok;
  logic [HPOS_W-1:0]          cen_x;
  logic                       usable;
  logic                       hit;
  logic                       late;
  logic                       apply;
  logic                       last_in;
  logic [IRQ_W-1:0]           ev;
  logic [PIX_W-1:0]           rep_pix;
  logic                       op_ok;

  assign reg_rdata = rdata_reg;
  assign mem_req   = mem_req_reg;
  assign mem_addr  = mem_addr_reg;
  assign out_valid = out_valid_reg;
  assign out_data  = out_data_reg;
  assign irq       = irq_reg;

  // register port decode
  assign ctl_wr  = reg_req.wr && reg_req.addr == OFS_CTRL;
  assign en_rise = ctl_wr && reg_req.wdata[EN_BIT] && !en_reg;       // RL2
  assign base    = {tsa_reg[31:ALIGN_LSB], ALIGN_LSB'(0)};           // RL6

  // control and address registers
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      en_reg     <= 1'b0;
      dcount_reg <= CNT_RESET;
      tsa_reg    <= TSA_RESET;
      mask_reg   <= IRQ_RESET;
    end
    else if (reg_req.wr)
    begin
      case (reg_req.addr)
        OFS_CTRL:
        begin
          en_reg     <= reg_req.wdata[EN_BIT];                        // RL5
          dcount_reg <= reg_req.wdata[CNT_W-1:0];
        end
        OFS_TSA:      tsa_reg  <= reg_req.wdata;
        OFS_IRQ_MASK: mask_reg <= reg_req.wdata[IRQ_W-1:0];
        default:      ;
      endcase
    end
  end

  // count takes effect only from the next frame
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      cnt_reg <= CNT_RESET;
    else if (vertical_sync)
      cnt_reg <= dcount_reg;                                          // RL4
  end

  // read data, one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata_reg <= 32'h0000_0000;
    else if (reg_req.rd)
    begin
      case (reg_req.addr)
        OFS_CTRL:
          rdata_reg <= {15'h0000, stat_reg[IRQ_LATE], en_reg, dcount_reg};
        OFS_TSA:      rdata_reg <= tsa_reg;
        OFS_IRQ_STAT: rdata_reg <= {30'h0, stat_reg};
        OFS_IRQ_MASK: rdata_reg <= {30'h0, mask_reg};
        OFS_POS:      rdata_reg <= {3'h0, line_reg, 2'h0, x_reg};
        default:      rdata_reg <= 32'h0000_0000;
      endcase
    end
    else
      rdata_reg <= 32'h0000_0000;
  end

  // raster position of the incoming pixel
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      line_reg <= '0;
      x_reg    <= '0;
    end
    else if (vertical_sync)
    begin
      line_reg <= '0;
      x_reg    <= '0;
    end
    else if (line_start)
    begin
      line_reg <= line_reg + LINE_W'(1);
      x_reg    <= '0;
    end
    else if (pix_valid)
      x_reg <= x_reg + HPOS_W'(1);
  end

  // window after this cycle's push; centre is six pixels behind
  always_comb
  begin
    win_next = win_reg;
    if (pix_valid)
      win_next = {win_reg[WIN_N-2:0], pix_data};
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      win_reg <= '0;
    else
      win_reg <= win_next;
  end

  // the last six pixels of a line never reach the centre in-line,
  // so they pass untouched; saves a line-end flush
  assign cen_ok = pix_valid && x_reg >= HPOS_W'(REACH);
  assign cen_x  = x_reg - HPOS_W'(REACH);
  assign usable = en_reg && ent_valid_reg && !ent_next_reg
                  && !frame_err_reg;
  assign hit    = usable && cen_ok && line_reg == ent_reg.line
                  && cen_x == ent_reg.hpos;                           // RL14
  assign late   = usable && cen_ok && (line_reg > ent_reg.line
                  || (line_reg == ent_reg.line
                      && cen_x > ent_reg.hpos));                      // RL12
  assign apply  = hit && op_ok;                                       // RL13

  neighbour_select #(
    .PIX_W (PIX_W)
  ) u_sel (
    .win   (win_next),
    .op    (ent_reg.op),                                              // RL8
    .pix   (rep_pix),
    .op_ok (op_ok)
  );

  // corrected stream, one cycle after the push
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end
    else
    begin
      out_valid_reg <= pix_valid;
      if (pix_valid)
        out_data_reg <= apply ? rep_pix : win_next[CEN];              // RL9
    end
  end

  assign last_in = fstate_reg == F_WAIT && mem_rvalid && !restart_reg
                   && en_reg && idx_reg == cnt_reg - CNT_W'(1);

  // table fetch: one entry held, one request outstanding at most
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fstate_reg    <= F_IDLE;
      mem_req_reg   <= 1'b0;
      mem_addr_reg  <= 32'h0000_0000;
      idx_reg       <= '0;
      wrap_reg      <= 1'b0;
      restart_reg   <= 1'b0;
      ent_valid_reg <= 1'b0;
      ent_next_reg  <= 1'b0;
      ent_reg       <= '0;
    end
    else
    begin
      if (hit || late)
        ent_valid_reg <= 1'b0;                                        // RL14
      case (fstate_reg)
        F_IDLE:
          if (en_reg && !ent_valid_reg && cnt_reg != '0)
          begin
            mem_req_reg  <= 1'b1;                                     // RL1
            mem_addr_reg <= base + {15'h0, idx_reg, 2'h0};            // RL6
            fstate_reg   <= F_WAIT;
          end
        F_WAIT:
          if (mem_rvalid)
          begin
            mem_req_reg <= 1'b0;
            fstate_reg  <= F_IDLE;
            restart_reg <= 1'b0;
            if (!restart_reg && en_reg)
            begin
              ent_reg       <= entry_t'(mem_rdata);                   // RL7
              ent_valid_reg <= 1'b1;
              ent_next_reg  <= wrap_reg;
              if (last_in)
              begin
                idx_reg  <= '0;                                       // RL1
                wrap_reg <= 1'b1;
              end
              else
                idx_reg <= idx_reg + CNT_W'(1);
            end
          end
        default: fstate_reg <= F_IDLE;
      endcase
      // an answer still owed for the old table is thrown away
      if (en_rise)
      begin
        ent_valid_reg <= 1'b0;                                        // RL2
        idx_reg       <= '0;
        wrap_reg      <= 1'b0;
        restart_reg   <= fstate_reg == F_WAIT && !mem_rvalid;
      end
      if (vertical_sync)
      begin
        ent_next_reg <= 1'b0;
        wrap_reg     <= 1'b0;
      end
    end
  end

  // late flag blocks corrections until the next frame
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      frame_err_reg <= 1'b0;
    else if (vertical_sync)
      frame_err_reg <= 1'b0;
    else if (late)
      frame_err_reg <= 1'b1;                                          // RL12
  end

  // sticky status, write one to clear, a new event beats the clear
  assign ev = {last_in, late};

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      stat_reg <= IRQ_RESET;
    else
    begin
      if (reg_req.wr && reg_req.addr == OFS_IRQ_STAT)
        stat_reg <= (stat_reg & ~reg_req.wdata[IRQ_W-1:0]) | ev;
      else if (ctl_wr && reg_req.wdata[ERR_BIT])
        stat_reg <= (stat_reg & ~(IRQ_W'(1) << IRQ_LATE)) | ev;      // RL12
      else
        stat_reg <= stat_reg | ev;
    end
  end

  // level interrupt, one cycle behind the status
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      irq_reg <= 1'b0;
    else
      irq_reg <= |(stat_reg & mask_reg);
  end

  // checks beside the logic
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  req_held_a: assert property (mem_req_reg && !mem_rvalid |=> mem_req_reg) // RL1
    else $error("fetch request dropped before answer");
  start_fetch_a: assert property (en_rise && fstate_reg == F_IDLE // RL2
      && cnt_reg != '0 && !vertical_sync |-> ##[1:2] mem_req_reg)
    else $error("enable did not start fetching");
  count_latch_a: assert property (vertical_sync // RL4
      |=> cnt_reg == $past(dcount_reg))
    else $error("count not latched at vertical sync");
  enable_bit_a: assert property (ctl_wr // RL5
      |=> en_reg == $past(reg_req.wdata[15]))
    else $error("enable bit misdecoded");
  first_addr_a: assert property ($rose(mem_req_reg) && idx_reg == '0 // RL6
      |-> mem_addr_reg[5:0] == 6'h00)
    else $error("first entry address not aligned");
  entry_field_a: assert property (fstate_reg == F_WAIT && mem_rvalid // RL7
      && en_reg && !restart_reg && !en_rise
      |=> ent_reg.hpos == $past(mem_rdata[18:5]) && ent_valid_reg)
    else $error("entry fields misplaced");
  avg_one_a: assert property (pix_valid && apply && ent_reg.op == 5'h00 // RL9
      |=> out_data_reg == PIX_W'(({1'b0, $past(win_next[CEN+1])}
          + {1'b0, $past(win_next[CEN-1])}) >> 1))
    else $error("average of x-1 and x+1 wrong");
  left_six_a: assert property (apply && ent_reg.op == 5'h10 // RL10
      |=> out_data_reg == $past(win_next[CEN+6]))
    else $error("copy of x-6 wrong");
  right_two_a: assert property (apply && ent_reg.op == 5'h05 // RL11
      |=> out_data_reg == $past(win_next[CEN-2]))
    else $error("copy of x+2 wrong");
  late_stop_a: assert property (late && !vertical_sync // RL12
      |=> stat_reg[IRQ_LATE] && frame_err_reg && !apply)
    else $error("late entry not flagged");
  reserved_op_a: assert property (hit && ent_reg.op >= OP_RSVD // RL13
      |=> out_data_reg == $past(win_next[CEN]))
    else $error("reserved code changed a pixel");
  consume_a: assert property (hit && !en_rise |=> !ent_valid_reg) // RL14
    else $error("matched entry not consumed");

  fetch_wrap_c: cover property (last_in ##[1:40] $rose(mem_req_reg));
  apply_avg_c: cover property (apply && ent_reg.op == 5'h0f);
  late_c: cover property (late);
  irq_c: cover property ($rose(irq_reg));

endmodule

// *** test/fetch_memory.sv ***
// table memory model answering the fetch link of the correction block
`timescale 1ns/10ps
module fetch_memory
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // answer delay in cycles, one or more
  input  wire logic [7:0]  lat,
  // fetch link
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  output logic             mem_rvalid,
  output logic [31:0]      mem_rdata
);
  logic [31:0] words [0:255];
  logic [7:0]  wait_cnt;
  logic        busy;

  // one answer per request; data toggles outside the answer cycle
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      busy       <= 1'b0;
      wait_cnt   <= 8'h00;
      mem_rvalid <= 1'b0;
      mem_rdata  <= 32'h5a5a_a5a5;
    end
    else if (mem_rvalid)
    begin
      mem_rvalid <= 1'b0;
      busy       <= 1'b0;
      mem_rdata  <= ~mem_rdata;
    end
    else if (mem_req && !busy)
    begin
      busy      <= 1'b1;
      wait_cnt  <= lat;
      mem_rdata <= ~mem_rdata;
    end
    else if (busy && wait_cnt <= 8'h01)
    begin
      mem_rvalid <= 1'b1;
      mem_rdata  <= words[mem_addr[9:2]];
    end
    else
    begin
      wait_cnt  <= wait_cnt - 8'h01;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

// *** test/test_defect_pixel_correct.sv ***
// self-checking bench for the defect pixel correction block
`timescale 1ns/10ps
module test_defect_pixel_correct;
  import fpc_pkg::*;
  localparam int          W    = 32;
  localparam logic [31:0] BASE = 32'h1234_5600;
  logic        core_clk, reset_n, mem_req, mem_rvalid, irq;
  reg_req_t    reg_req;
  logic [31:0] reg_rdata, mem_addr, mem_rdata, v, r;
  logic        vertical_sync, line_start, pix_valid, out_valid;
  logic [9:0]  pix_data, out_data;
  logic [7:0]  lat;
  logic [4:0]  ops [0:25];
  logic [13:0] pos [0:25];
  logic [9:0]  row [0:W-1];
  logic [4:0]  ofs [0:4];
  int          fail_count, num_checks, exp_idx, cnt_lat, cnt_w, mon_on;

  defect_pixel_correct #(.PIX_W(10)) uut (.core_clk(core_clk),
    .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata), .vertical_sync(vertical_sync),
    .line_start(line_start), .pix_valid(pix_valid), .pix_data(pix_data),
    .out_valid(out_valid), .out_data(out_data), .irq(irq));
  fetch_memory mem (.core_clk(core_clk), .reset_n(reset_n), .lat(lat),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid),
    .mem_rdata(mem_rdata));

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic reg_wr(logic [4:0] a, logic [31:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    reg_req.wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic reg_rd(logic [4:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    reg_req.rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic ctrl_wr(logic en, int cnt, logic clr);
    cnt_w = cnt;
    reg_wr(OFS_CTRL, {15'h0, clr, en, 15'(cnt)});
  endtask

  task automatic pulse_vs();
    @(posedge core_clk);
    vertical_sync <= 1'b1;
    @(posedge core_clk);
    vertical_sync <= 1'b0;
    cnt_lat = cnt_w;
  endtask

  // enable write must raise the fetch one edge after it is taken; checked two edges after
  task automatic check_start();
    repeat (2) @(posedge core_clk);
    #1;
    check("mem_req", 32'(mem_req), 32'h1);
    check("mem_addr", mem_addr, BASE);
  endtask

  function automatic logic [9:0] expect_pix(logic [4:0] op, int p);
    int n;
    n = int'(op) / 3 + 1;
    if (op >= OP_RSVD) return row[p];
    case (int'(op) % 3)
      0: return 10'((11'(row[p-n]) + 11'(row[p+n])) >> 1);
      1: return row[p-n];
      default: return row[p+n];
    endcase
  endfunction

  // push lines of random pixels; line l uses entry l while l < nc
  task automatic run_lines(int nl, int nc);
    int p;
    for (int l = 0; l < nl; l++)
    begin
      for (int x = 0; x < W; x++) row[x] = 10'($urandom);
      p = (l < nc) ? int'(pos[l]) : -1;
      if (l > 0)
      begin
        @(posedge core_clk);
        line_start <= 1'b1;
        @(posedge core_clk);
        line_start <= 1'b0;
      end
      for (int x = 0; x < W; x++)
      begin
        @(posedge core_clk);
        pix_valid <= 1'b1;
        pix_data  <= row[x];
        @(posedge core_clk);
        pix_valid <= 1'b0;
        #1;
        check("out_valid", 32'(out_valid), 32'h1);
        if (x >= 6)
          check("out_data", 32'(out_data), (x - 6 == p) ?
            32'(expect_pix(ops[l], p)) : 32'(row[x-6]));
      end
    end
  endtask

  // every taken entry must come from the next address in the table
  always @(negedge core_clk)
    if (mon_on != 0 && mem_req && mem_rvalid)
    begin
      check("fetch_addr", mem_addr, BASE + 32'(4 * exp_idx));
      exp_idx = (exp_idx + 1) % cnt_lat;
    end

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // a hang ends the run as a failure
  initial
  begin
    #500_000;
    fail_count++;
    finish_test();
  end

  initial
  begin
    reset_n = 1'b0;
    reg_req = '0;
    {vertical_sync, line_start, pix_valid} = 3'h0;
    pix_data = 10'h000;
    lat = 8'h02;
    {mon_on, exp_idx, cnt_lat, cnt_w} = {32'd0, 32'd0, 32'd1, 32'd0};
    ofs = '{OFS_CTRL, OFS_TSA, OFS_IRQ_STAT, OFS_IRQ_MASK, 5'h14};
    v = $urandom(32'h44605a0f);
    for (int i = 0; i < 26; i++)
    begin
      ops[i] = (i < 24) ? 5'(i) : ((i == 24) ? 5'h18 : 5'h1f);
      pos[i] = (i < 2) ? 14'((i == 0) ? 6 : W - 7)
                       : 14'($urandom_range(6, W - 7));
      mem.words[8'h80 + 8'(i)] = {13'(i), pos[i], ops[i]};
    end
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    // reset values, unmapped read, full-width writes
    for (int i = 0; i < 5; i++)
    begin
      reg_rd(ofs[i], v);
      check("reset_read", v, 32'h0);
    end
    r = $urandom;
    reg_wr(OFS_TSA, r);
    reg_rd(OFS_TSA, v);
    check("tsa_rw", v, r);
    reg_wr(OFS_CTRL, 32'hfffe_7fff);
    reg_rd(OFS_CTRL, v);
    check("ctrl_rw", v, 32'h0000_7fff);
    // load the table: address, disable, enable
    reg_wr(OFS_TSA, BASE | 32'h2b);
    ctrl_wr(1'b0, 26, 1'b0);
    pulse_vs();
    mon_on = 1;
    ctrl_wr(1'b1, 26, 1'b0);
    check_start();
    lat = 8'($urandom_range(1, 4));
    pulse_vs();
    run_lines(26, 26);
    reg_rd(OFS_IRQ_STAT, v);
    check("wrap_flag", 32'(v[IRQ_WRAP]), 32'h1);
    check("irq_masked", 32'(irq), 32'h0);
    reg_wr(OFS_IRQ_MASK, 32'h2);
    repeat (2) @(posedge core_clk);
    #1;
    check("irq_set", 32'(irq), 32'h1);
    reg_wr(OFS_IRQ_STAT, 32'h2);
    repeat (2) @(posedge core_clk);
    #1;
    check("irq_clear", 32'(irq), 32'h0);
    // new count takes effect only at the next frame
    pulse_vs();
    ctrl_wr(1'b1, 2, 1'b0);
    run_lines(26, 26);
    pulse_vs();
    run_lines(4, 2);
    // slow memory: second entry arrives late
    lat = 8'd200;
    reg_wr(OFS_IRQ_MASK, 32'h1);
    pulse_vs();
    run_lines(5, 1);
    lat = 8'h02;
    reg_rd(OFS_IRQ_STAT, v);
    check("late_flag", 32'(v[IRQ_LATE]), 32'h1);
    reg_rd(OFS_CTRL, v);
    check("late_ctrl", 32'(v[ERR_BIT]), 32'h1);
    check("irq_late", 32'(irq), 32'h1);
    ctrl_wr(1'b1, 2, 1'b1);
    reg_rd(OFS_IRQ_STAT, v);
    check("late_clear", 32'(v[IRQ_LATE]), 32'h0);
    check("irq_idle", 32'(irq), 32'h0);
    repeat (250) @(posedge core_clk);
    // reload with stray low address bits
    mon_on = 0;
    reg_wr(OFS_TSA, BASE | 32'h3f);
    ctrl_wr(1'b0, 2, 1'b0);
    repeat (10) @(posedge core_clk);
    exp_idx = 0;
    mon_on = 1;
    ctrl_wr(1'b1, 2, 1'b0);
    check_start();
    pulse_vs();
    run_lines(3, 2);
    // raster position after two line starts and 32 pixels
    reg_rd(OFS_POS, v);
    check("pos_read", v, 32'h0002_0020);
    finish_test();
  end
endmodule
